// ---- pmt_pkg.sv ----
// What this block does
// - Program store of 512 or 1024 16-bit words
// - Program counter addresses instruction fetches
// - Fetching starts at word zero after reset
// - Full table address built from both pointer registers
// - Any word may be read as table
// - Low byte goes to operand data register
// - High byte loads the table latch
// - Missing high-byte bits read as zero
// - Page-relative read offsets from current page
// - Latch read-only, overwritten by each read
// - Table instructions take two instruction cycles
// - Programming uses one serial data pin, external clock
// - Debug pins override shared functions when debugging
// - Debug pins still serve as programming pins
// - A page spans 256 words
package pmt_pkg;
   localparam int PMT_WORD_W = 16;
   localparam int PMT_BYTE_W = 8;
   localparam int PMT_PAGE_W = 8;
   localparam int PMT_DEPTH_DEF = 1024;
   localparam int PMT_DATA_ADDR_W = 8;
   localparam logic [15:0] PMT_RESET_VECTOR = 16'h0000;
   localparam int PMT_TABLE_CYCLES = 2;

   typedef enum logic [1:0] {
      PMT_OP_NONE,
      PMT_OP_TABLE_FULL,
      PMT_OP_TABLE_PAGE
   } pmt_op_e;

   typedef struct packed {
      logic [PMT_BYTE_W-1:0] data;
      logic [PMT_DATA_ADDR_W-1:0] addr;
      logic we;
   } pmt_dwr_s;

   typedef struct packed {
      logic data_in;
      logic clk_in;
      logic data_out;
      logic data_oe;
   } pmt_pins_s;
endpackage

// ---- pmt_sync.sv ----
`timescale 1ns/100ps
module pmt_sync (
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic d_i,
   output logic q_o
);
   logic s1_r;

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         s1_r <= 1'b0;
         q_o <= 1'b0;
      end else begin
         s1_r <= d_i;
         q_o <= s1_r;
      end
   end
endmodule

// ---- pmt_table_read.sv ----
`timescale 1ns/100ps
module pmt_table_read
   import pmt_pkg::*;
#(
   parameter int DEPTH = PMT_DEPTH_DEF,
   parameter int STORED_W = PMT_WORD_W,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic RUN_I,
   input wire logic [AW-1:0] PC_I,
   input wire logic PC_LOAD_I,
   input wire logic [PMT_BYTE_W-1:0] TBL_LOW_PTR_I,
   input wire logic [PMT_BYTE_W-1:0] TBL_HIGH_PTR_I,
   input wire pmt_op_e OP_I,
   input wire logic [PMT_DATA_ADDR_W-1:0] OPERAND_I,
   input wire logic PROG_WE_I,
   input wire logic [AW-1:0] PROG_ADDR_I,
   input wire logic [PMT_WORD_W-1:0] PROG_DATA_I,
   input wire logic DEBUG_MODE_I,
   input wire logic PROG_SERIAL_DATA_I,
   input wire logic PROG_SERIAL_CLOCK_I,
   input wire logic PROG_SERIAL_DATA_TX_I,
   input wire logic PROG_SERIAL_DATA_TX_EN_I,
   output logic [PMT_WORD_W-1:0] INSTR_O,
   output logic [AW-1:0] FETCH_ADDR_O,
   output logic INSTR_VALID_O,
   output logic BUSY_O,
   output pmt_dwr_s DWR_O,
   output logic [PMT_BYTE_W-1:0] TABLE_HIGH_BYTE_LATCH_O,
   output logic PROG_SERIAL_DATA_O,
   output logic PROG_SERIAL_DATA_OE_O,
   output logic PROG_SERIAL_DATA_SYNC_O,
   output logic PROG_SERIAL_CLOCK_SYNC_O,
   output logic PORT_SHARED_BLOCK_O
);
   typedef enum logic [1:0] {PMT_ST_RESET, PMT_ST_FETCH, PMT_ST_TABLE} pmt_state_e;

   logic [PMT_WORD_W-1:0] mem_r [DEPTH];
   pmt_state_e state_r;
   logic [AW-1:0] pc_r;
   logic [AW-1:0] tbl_addr_nxt;
   logic [AW-1:0] tbl_addr_r;
   logic [PMT_DATA_ADDR_W-1:0] operand_r;
   logic [PMT_WORD_W-1:0] tbl_word;
   logic [PMT_WORD_W-1:0] stored_mask;
   logic [PMT_WORD_W-1:0] masked_word;
   logic [PMT_WORD_W-1:0] full_ptr;
   logic sd_sync;
   logic sc_sync;

   // Stored words narrower than 16 bits read their missing bits as zero
   assign stored_mask = PMT_WORD_W'((32'h0000_0001 << STORED_W) - 1);

   // Full pointer: low register gives low byte, high register the rest
   assign full_ptr = {TBL_HIGH_PTR_I, TBL_LOW_PTR_I};

   always_comb begin
      if (OP_I == PMT_OP_TABLE_PAGE) begin
         // Offset within the page holding the current program counter
         tbl_addr_nxt = AW'({pc_r[AW-1:PMT_PAGE_W], TBL_LOW_PTR_I});
      end else begin
         tbl_addr_nxt = full_ptr[AW-1:0];
      end
   end

   assign tbl_word = mem_r[tbl_addr_r];
   assign masked_word = tbl_word & stored_mask;

   // Program store written by the programming path
   always_ff @(posedge CLOCK_I) begin
      if (PROG_WE_I) begin
         mem_r[PROG_ADDR_I] <= PROG_DATA_I & stored_mask;
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_r <= PMT_ST_RESET;
         pc_r <= '0;
         tbl_addr_r <= '0;
         operand_r <= '0;
      end else begin
         unique case (state_r)
            PMT_ST_RESET: begin
               pc_r <= AW'(PMT_RESET_VECTOR);
               if (RUN_I) begin
                  state_r <= PMT_ST_FETCH;
               end
            end
            PMT_ST_FETCH: begin
               if (RUN_I && OP_I != PMT_OP_NONE) begin
                  tbl_addr_r <= tbl_addr_nxt;
                  operand_r <= OPERAND_I;
                  state_r <= PMT_ST_TABLE;
               end else if (RUN_I) begin
                  pc_r <= PC_LOAD_I ? PC_I : AW'(pc_r + 1'b1);
               end
            end
            PMT_ST_TABLE: begin
               pc_r <= PC_LOAD_I ? PC_I : AW'(pc_r + 1'b1);
               state_r <= PMT_ST_FETCH;
            end
            default: state_r <= PMT_ST_RESET;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         INSTR_O <= '0;
         FETCH_ADDR_O <= '0;
         INSTR_VALID_O <= 1'b0;
         BUSY_O <= 1'b0;
      end else begin
         INSTR_O <= mem_r[pc_r] & stored_mask;
         FETCH_ADDR_O <= pc_r;
         INSTR_VALID_O <= RUN_I && state_r == PMT_ST_FETCH && OP_I == PMT_OP_NONE;
         BUSY_O <= state_r == PMT_ST_FETCH && RUN_I && OP_I != PMT_OP_NONE;
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         DWR_O <= '0;
         TABLE_HIGH_BYTE_LATCH_O <= '0;
      end else begin
         DWR_O.we <= 1'b0;
         if (state_r == PMT_ST_TABLE) begin
            DWR_O.we <= 1'b1;
            DWR_O.addr <= operand_r;
            DWR_O.data <= masked_word[PMT_BYTE_W-1:0];
            TABLE_HIGH_BYTE_LATCH_O <= masked_word[PMT_WORD_W-1:PMT_BYTE_W];
         end
      end
   end

   pmt_sync u_sync_data (
      .CLOCK_I(CLOCK_I),
      .NRST_I(NRST_I),
      .d_i(PROG_SERIAL_DATA_I),
      .q_o(sd_sync)
   );

   pmt_sync u_sync_clock (
      .CLOCK_I(CLOCK_I),
      .NRST_I(NRST_I),
      .d_i(PROG_SERIAL_CLOCK_I),
      .q_o(sc_sync)
   );

   // Pin roles for programming and debug; the shared functions are held off while DEBUG_MODE_I is set
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         PROG_SERIAL_DATA_O <= 1'b0;
         PROG_SERIAL_DATA_OE_O <= 1'b0;
         PROG_SERIAL_DATA_SYNC_O <= 1'b0;
         PROG_SERIAL_CLOCK_SYNC_O <= 1'b0;
         PORT_SHARED_BLOCK_O <= 1'b0;
      end else begin
         PROG_SERIAL_DATA_O <= PROG_SERIAL_DATA_TX_I;
         PROG_SERIAL_DATA_OE_O <= PROG_SERIAL_DATA_TX_EN_I;
         PROG_SERIAL_DATA_SYNC_O <= sd_sync;
         PROG_SERIAL_CLOCK_SYNC_O <= sc_sync;
         PORT_SHARED_BLOCK_O <= DEBUG_MODE_I;
      end
   end

   property p_table_two_cycles;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      (state_r == PMT_ST_FETCH && RUN_I && OP_I != PMT_OP_NONE)
         |=> state_r == PMT_ST_TABLE ##1 state_r == PMT_ST_FETCH;
   endproperty
   a_table_two_cycles: assert property (p_table_two_cycles)
      else $error("table instruction not two cycles");

   property p_low_byte;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      state_r == PMT_ST_TABLE
         |=> DWR_O.we && DWR_O.data == $past(masked_word[PMT_BYTE_W-1:0]);
   endproperty
   a_low_byte: assert property (p_low_byte)
      else $error("low table byte not written");

   property p_high_byte;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      state_r == PMT_ST_TABLE
         |=> TABLE_HIGH_BYTE_LATCH_O == $past(masked_word[PMT_WORD_W-1:PMT_BYTE_W]);
   endproperty
   a_high_byte: assert property (p_high_byte)
      else $error("high table byte not latched");

   property p_latch_hold;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      state_r != PMT_ST_TABLE |=> $stable(TABLE_HIGH_BYTE_LATCH_O);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("high byte latch changed without table read");

   property p_page_addr;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      (state_r == PMT_ST_FETCH && RUN_I && OP_I == PMT_OP_TABLE_PAGE)
         |=> tbl_addr_r[PMT_PAGE_W-1:0] == $past(TBL_LOW_PTR_I)
             && tbl_addr_r[AW-1:PMT_PAGE_W] == $past(pc_r[AW-1:PMT_PAGE_W]);
   endproperty
   a_page_addr: assert property (p_page_addr)
      else $error("page relative address wrong");

   property p_full_addr;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      (state_r == PMT_ST_FETCH && RUN_I && OP_I == PMT_OP_TABLE_FULL)
         |=> tbl_addr_r == $past(full_ptr[AW-1:0]);
   endproperty
   a_full_addr: assert property (p_full_addr)
      else $error("full table address wrong");

   property p_reset_vector;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      state_r == PMT_ST_RESET |=> pc_r == '0;
   endproperty
   a_reset_vector: assert property (p_reset_vector)
      else $error("fetch does not start at zero");

   property p_unused_zero;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      1'b1 |-> (TABLE_HIGH_BYTE_LATCH_O & ~stored_mask[PMT_WORD_W-1:PMT_BYTE_W]) == '0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused high bits not zero");
endmodule

// ---- pmt_cpu_model.sv ----
`timescale 1ns/100ps
module pmt_cpu_model
   import pmt_pkg::*;
(
   input wire logic clk_i,
   output logic run_o,
   output logic [9:0] pc_o,
   output logic pc_load_o,
   output logic [7:0] lo_o,
   output logic [7:0] hi_o,
   output pmt_op_e op_o,
   output logic [7:0] opd_o
);
   initial begin
      run_o = 1'b0;
      pc_o = 10'h000;
      pc_load_o = 1'b0;
      lo_o = 8'h00;
      hi_o = 8'h00;
      op_o = PMT_OP_NONE;
      opd_o = 8'h00;
   end
   task automatic start();
      @(negedge clk_i);
      run_o = 1'b1;
   endtask
   // No interrupt source here, so table reads never interleave
   task automatic issue(input pmt_op_e op, input logic [7:0] lo, hi, opd);
      @(negedge clk_i);
      lo_o = lo;
      hi_o = hi;
      opd_o = opd;
      op_o = op;
      @(negedge clk_i);
      op_o = PMT_OP_NONE;
   endtask
   task automatic jump(input logic [9:0] pc);
      @(negedge clk_i);
      pc_o = pc;
      pc_load_o = 1'b1;
      @(negedge clk_i);
      pc_load_o = 1'b0;
   endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   import pmt_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic run, pc_load, pwe, dbg, sd, sc, tx, tx_en;
   logic [9:0] pc, paddr, faddr;
   logic [7:0] lo, hi, opd, latch;
   logic [15:0] pdata, instr;
   logic ivalid, busy, sd_o, sd_oe, sd_s, sc_s, blk;
   pmt_op_e op;
   pmt_dwr_s dwr;
   logic [15:0] mem [1024];
   int bad_count = 0;
   int samples_checked = 0;
   always #50 clk = ~clk;
   initial begin
      pwe = 1'b0;
      paddr = 10'h000;
      pdata = 16'h0000;
      dbg = 1'b0;
      sd = 1'b1;
      sc = 1'b0;
      tx = 1'b0;
      tx_en = 1'b0;
   end
   pmt_cpu_model cpu (.clk_i(clk), .run_o(run), .pc_o(pc), .pc_load_o(pc_load), .lo_o(lo),
      .hi_o(hi), .op_o(op), .opd_o(opd));
   pmt_table_read #(.DEPTH(1024), .STORED_W(14)) uut (.CLOCK_I(clk), .NRST_I(nrst),
      .RUN_I(run), .PC_I(pc), .PC_LOAD_I(pc_load), .TBL_LOW_PTR_I(lo),
      .TBL_HIGH_PTR_I(hi), .OP_I(op), .OPERAND_I(opd), .PROG_WE_I(pwe),
      .PROG_ADDR_I(paddr), .PROG_DATA_I(pdata), .DEBUG_MODE_I(dbg),
      .PROG_SERIAL_DATA_I(sd), .PROG_SERIAL_CLOCK_I(sc), .PROG_SERIAL_DATA_TX_I(tx),
      .PROG_SERIAL_DATA_TX_EN_I(tx_en), .INSTR_O(instr), .FETCH_ADDR_O(faddr),
      .INSTR_VALID_O(ivalid), .BUSY_O(busy), .DWR_O(dwr), .TABLE_HIGH_BYTE_LATCH_O(latch),
      .PROG_SERIAL_DATA_O(sd_o), .PROG_SERIAL_DATA_OE_O(sd_oe),
      .PROG_SERIAL_DATA_SYNC_O(sd_s), .PROG_SERIAL_CLOCK_SYNC_O(sc_s),
      .PORT_SHARED_BLOCK_O(blk));
   task automatic print_verdict();
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic wr_word(input logic [9:0] a, input logic [15:0] d);
      @(negedge clk);
      pwe = 1'b1;
      paddr = a;
      pdata = d;
      mem[a] = d;
   endtask
   // Low byte at the operand address and high byte as stored, bits 14 and up read as zero
   task automatic tbl_done(input logic [9:0] a, input logic [7:0] o);
      chk_bit(dwr.we, 1'b1);
      chk_word({8'h00, dwr.data}, {8'h00, mem[a][7:0]});
      chk_word({8'h00, dwr.addr}, {8'h00, o});
      chk_word({8'h00, latch}, {8'h00, mem[a][15:8] & 8'h3F});
   endtask
   task automatic t_vector();
      cpu.start();
      for (int i = 0; i < 8 && ivalid !== 1'b1; i++)
         @(negedge clk);
      chk_bit(ivalid, 1'b1);
      chk_word({6'h00, faddr}, 16'h0000);
      chk_word(instr, mem[0]);
   endtask
   task automatic t_full();
      cpu.issue(PMT_OP_TABLE_FULL, 8'h06, 8'h03, 8'h41);
      chk_bit(busy, 1'b1);
      chk_bit(dwr.we, 1'b0);
      @(negedge clk);
      tbl_done(10'h306, 8'h41);
      @(negedge clk);
      chk_bit(dwr.we, 1'b0);
   endtask
   task automatic t_page();
      cpu.jump(10'h300);
      cpu.issue(PMT_OP_TABLE_PAGE, 8'h05, 8'h00, 8'h52);
      @(negedge clk);
      tbl_done(10'h305, 8'h52);
   endtask
   task automatic t_back();
      cpu.issue(PMT_OP_TABLE_FULL, 8'h06, 8'h03, 8'h60);
      // Second read is posted in the cycle in which the first result stands
      fork
         cpu.issue(PMT_OP_TABLE_FULL, 8'hFF, 8'hFF, 8'h61);
         begin
            @(negedge clk);
            tbl_done(10'h306, 8'h60);
         end
      join
      @(negedge clk);
      tbl_done(10'h3FF, 8'h61);
   endtask
   task automatic t_pins();
      @(negedge clk);
      dbg = 1'b1;
      sd = 1'b0;
      sc = 1'b1;
      @(negedge clk);
      chk_bit(blk, 1'b1);
      @(negedge clk);
      chk_bit(sc_s, 1'b0);
      @(negedge clk);
      chk_bit(sc_s, 1'b1);
      chk_bit(sd_s, 1'b0);
      // Host lets go of the data pin in the same cycle that the block starts to drive it
      sd = 1'b1;
      tx = 1'b1;
      tx_en = 1'b1;
      @(negedge clk);
      chk_bit(sd_o, 1'b1);
      chk_bit(sd_oe, 1'b1);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      wr_word(10'h000, 16'h2A5C);
      wr_word(10'h305, 16'h0C0F);
      wr_word(10'h306, 16'hFF1A);
      wr_word(10'h3FF, 16'h3E81);
      @(negedge clk);
      pwe = 1'b0;
      t_vector();
      t_full();
      t_page();
      t_back();
      t_pins();
      print_verdict();
   end
   initial begin
      #300000;
      bad_count++;
      print_verdict();
   end
endmodule
